// ---- hdl/sfct_pkg.sv ----
/*
 * Shared constants and types for the serial flash full-cycle link and
 * operation timer block.
 * Assumes a 20 MHz core clock; every cycle count below except SYNC_CYC is derived from it.
 */
package sfct_pkg;

    localparam int CLK_MHZ          = 20;
    localparam int US_PER_MS        = 1000;
    localparam int SYNC_CYC         = 3;

    localparam int T_XFR_US         = 100;
    localparam int T_COMP_US        = 100;
    localparam int T_EUDPD_US       = 3;
    localparam int T_XUDPD_WIDE_US  = 240;
    localparam int T_XUDPD_HI_US    = 120;
    localparam int T_EDPD_US        = 2;
    localparam int T_RDPD_US        = 35;
    localparam int T_WP_US          = 1;
    localparam int T_SWRST_US       = 35;
    localparam int T_EP_TYP_MS      = 10;
    localparam int T_EP_MAX_WIDE_MS = 35;
    localparam int T_EP_MAX_HI_MS   = 25;

    localparam int XFR_CYC          = T_XFR_US * CLK_MHZ;
    localparam int COMP_CYC         = T_COMP_US * CLK_MHZ;
    localparam int EUDPD_CYC        = T_EUDPD_US * CLK_MHZ;
    localparam int XUDPD_HI_CYC     = T_XUDPD_HI_US * CLK_MHZ;
    localparam int EDPD_CYC         = T_EDPD_US * CLK_MHZ;
    localparam int RDPD_CYC         = T_RDPD_US * CLK_MHZ;
    localparam int WP_CYC           = T_WP_US * CLK_MHZ;
    localparam int SWRST_CYC        = T_SWRST_US * CLK_MHZ;

    localparam int CNT_W            = 20;
    localparam int BYTE_W           = 8;
    localparam int BUF_DEPTH        = 2;

    localparam logic [2:0]        BIT_FIRST    = 3'h0;
    localparam logic [2:0]        BIT_LAST     = 3'h7;
    localparam logic [BYTE_W-1:0] TX_IDLE_BYTE = 8'hFF;
    localparam logic [CNT_W-1:0]  CNT_ONE      = 20'h00001;
    localparam logic [CNT_W-1:0]  CNT_ZERO     = 20'h00000;

    typedef enum logic [2:0] {
        SFCT_OP_XFER,
        SFCT_OP_COMP,
        SFCT_OP_PAGE_EP,
        SFCT_OP_DPD_ENTER,
        SFCT_OP_DPD_RESUME,
        SFCT_OP_UDPD_ENTER,
        SFCT_OP_SW_RESET,
        SFCT_OP_WAKE
    } sfct_op_t;

    typedef enum logic [1:0] {
        SFCT_PWR_ACTIVE,
        SFCT_PWR_DPD,
        SFCT_PWR_UDPD
    } sfct_pwr_t;

    typedef enum logic [1:0] {
        SFCT_ST_IDLE,
        SFCT_ST_ARMED,
        SFCT_ST_RUN
    } sfct_state_t;

    typedef struct packed {
        sfct_op_t code;
    } sfct_op_req_t;

    typedef struct packed {
        logic      busy;
        logic      wp_prot;
        logic      range_hi;
        sfct_pwr_t pwr;
    } sfct_status_t;

endpackage

// ---- hdl/sfct_buf.sv ----
/*
 * Two-entry valid/ready buffer for received bytes.
 * Assumes both sides are on the core clock; the drain side may stall freely.
 */
module sfct_buf
    import sfct_pkg::*;
#(
    parameter int W     = BYTE_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [PW-1:0] wr_r;
    logic [PW-1:0] rd_r;
    logic [PW:0]   cnt_r;
    wire           push;
    wire           pop;

    assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_r];

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clock) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wrap_inc(wr_r);
            end
            if (pop) begin
                rd_r <= wrap_inc(rd_r);
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// ---- hdl/sfct_core.sv ----
/*
 * Serial flash full-cycle link and self-timed operation timer.
 * Assumes sck, cs_n, si, wp_n and range_hi come from pins; sck runs only in
 * frames, and the core clock runs at 20 MHz.
 */
// Summary of operation
// RQ1 Memory launches output bits on falling sck and captures inputs on rising sck.
// RQ2 Host samples each memory output bit at the following falling edge.
// RQ3 Host launches input bits on rising sck, giving a full period.
// RQ4 Each rising edge captures the previous bit while the host presents the next.
// RQ5 After the last input bit, output bits go out falling edge by falling edge.
// RQ6 Page to buffer transfer ends within 100 us of the command.
// RQ7 Page to buffer compare ends within 100 us of the command.
// RQ8 Ultra-low-power shutdown is reached within 3 us after chip select rises.
// RQ9 Host holds chip select low at least 20 ns to wake from shutdown.
// RQ10 Wake from shutdown takes at most 240 us, or 120 us in upper range.
// RQ11 Power-down is entered within 2 us after chip select rises.
// RQ12 Resume from power-down completes within 35 us; host waits that long.
// RQ13 Write-protect low enforces protection within 1 us.
// RQ14 Write-protect high lifts protection within 1 us.
// RQ15 Page erase and program takes 10 ms typical, 35 or 25 ms maximum.
// RQ16 Host keeps chip select high at least 20 ns between commands.
// RQ17 Busy shows during every self-timed operation, ready only after it ends.
// RQ18 Host times from chip select rising and waits the maximum duration.
module sfct_core
    import sfct_pkg::*;
#(
    parameter int P_EP_CYC          = T_EP_TYP_MS * US_PER_MS * CLK_MHZ,
    parameter int P_EP_MAX_WIDE_CYC = T_EP_MAX_WIDE_MS * US_PER_MS * CLK_MHZ,
    parameter int P_EP_MAX_HI_CYC   = T_EP_MAX_HI_MS * US_PER_MS * CLK_MHZ,
    parameter int P_XUDPD_WIDE_CYC  = T_XUDPD_WIDE_US * CLK_MHZ
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              sck,
    input  wire logic              cs_n,
    input  wire logic              si,
    output logic                   so,
    output logic                   so_oe,
    input  wire logic              wp_n,
    input  wire logic              range_hi,
    input  wire logic              op_valid,
    input  wire sfct_op_req_t      op_req,
    output logic                   op_ready,
    output logic                   rx_valid,
    output logic      [BYTE_W-1:0] rx_data,
    input  wire logic              rx_ready,
    input  wire logic              tx_valid,
    input  wire logic [BYTE_W-1:0] tx_data,
    output logic                   tx_ready,
    output sfct_status_t           status
);
    localparam int AST_EUDPD  = EUDPD_CYC;
    localparam int AST_EDPD   = EDPD_CYC;
    localparam int AST_RDPD   = RDPD_CYC;
    localparam int AST_WP     = WP_CYC;
    localparam int AST_XFR    = XFR_CYC;
    localparam int AST_COMP   = COMP_CYC;

    // Link domain, clocked by sck; frame logic is cleared by chip select high.
    wire                lrst;
    logic [2:0]         rbit_r;
    logic [BYTE_W-1:0]  rx_sr_r;
    logic [BYTE_W-1:0]  rx_hold_r;
    logic               rx_tog_r;
    logic [2:0]         fbit_r;
    logic [BYTE_W-1:0]  tx_sr_r;
    logic               treq_s1_r;
    logic               treq_s2_r;
    logic               tx_ack_r;
    wire  [BYTE_W-1:0]  rx_next;
    wire  [BYTE_W-1:0]  tx_load;

    // Core domain.
    logic               cs_s1_r;
    logic               cs_s2_r;
    logic               cs_s3_r;
    logic               wp_s1_r;
    logic               wp_s2_r;
    logic               rh_s1_r;
    logic               rh_s2_r;
    logic               rtog_s1_r;
    logic               rtog_s2_r;
    logic               rtog_s3_r;
    logic               ack_s1_r;
    logic               ack_s2_r;
    logic               wake_r;
    logic               wake_s1_r;
    logic               wake_s2_r;
    logic               wp_prot_r;
    logic               pend_r;
    logic [BYTE_W-1:0]  pend_data_r;
    logic               tx_req_r;
    logic [BYTE_W-1:0]  tx_hold_r;
    sfct_state_t        state_r;
    sfct_state_t        state_nxt;
    sfct_op_t           cur_op_r;
    sfct_pwr_t          pwr_r;
    sfct_pwr_t          pwr_nxt;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   age_r;
    wire                cs_rise;
    wire                rx_evt;
    wire                buf_in_ready;
    wire                op_ok;
    wire                op_take;
    wire                wake_go;
    wire                wake_clr;
    wire                run_done;

    assign lrst    = rst | cs_n;
    assign rx_next = {rx_sr_r[BYTE_W-2:0], si};
    assign tx_load = (treq_s2_r != tx_ack_r) ? tx_hold_r : TX_IDLE_BYTE;
    assign so      = tx_sr_r[BYTE_W-1];
    assign so_oe   = ~cs_n;

    // Input bits are taken on the rising edge. RQ1
    always_ff @(posedge sck or posedge lrst) begin
        if (lrst) begin
            rbit_r  <= BIT_FIRST;
            rx_sr_r <= '0;
        end else begin
            rbit_r  <= rbit_r + 3'h1; // RQ4
            rx_sr_r <= rx_next;
        end
    end

    // The toggle must survive chip select, otherwise the core sees a false byte.
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            rx_hold_r <= '0;
            rx_tog_r  <= 1'b0;
        end else if (!cs_n && rbit_r == BIT_LAST) begin
            rx_hold_r <= rx_next; // RQ4
            rx_tog_r  <= ~rx_tog_r;
        end
    end

    // Output bits change only on the falling edge; a byte loads right after the last input bit. RQ1
    always_ff @(negedge sck or posedge lrst) begin
        if (lrst) begin
            fbit_r  <= BIT_FIRST;
            tx_sr_r <= TX_IDLE_BYTE;
        end else begin
            fbit_r <= fbit_r + 3'h1;
            if (fbit_r == BIT_LAST) begin
                tx_sr_r <= tx_load; // RQ5
            end else begin
                tx_sr_r <= {tx_sr_r[BYTE_W-2:0], 1'b1}; // RQ5
            end
        end
    end

    always_ff @(negedge sck or posedge rst) begin
        if (rst) begin
            treq_s1_r <= 1'b0;
            treq_s2_r <= 1'b0;
            tx_ack_r  <= 1'b0;
        end else begin
            treq_s1_r <= tx_req_r;
            treq_s2_r <= treq_s1_r;
            if (!cs_n && fbit_r == BIT_LAST) begin
                tx_ack_r <= treq_s2_r;
            end
        end
    end

    // A wake pulse may be shorter than a core cycle, so it is caught asynchronously.
    assign wake_clr = (pwr_r != SFCT_PWR_UDPD);

    always_ff @(posedge clock or posedge rst or negedge cs_n) begin
        if (rst) begin
            wake_r <= 1'b0;
        end else if (!cs_n) begin
            wake_r <= 1'b1; // RQ9
        end else if (wake_clr) begin
            wake_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            cs_s3_r   <= 1'b1;
            wp_s1_r   <= 1'b1;
            wp_s2_r   <= 1'b1;
            rh_s1_r   <= 1'b0;
            rh_s2_r   <= 1'b0;
            rtog_s1_r <= 1'b0;
            rtog_s2_r <= 1'b0;
            rtog_s3_r <= 1'b0;
            ack_s1_r  <= 1'b0;
            ack_s2_r  <= 1'b0;
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
            wp_prot_r <= 1'b0;
        end else begin
            cs_s1_r   <= cs_n;
            cs_s2_r   <= cs_s1_r;
            cs_s3_r   <= cs_s2_r;
            wp_s1_r   <= wp_n;
            wp_s2_r   <= wp_s1_r;
            rh_s1_r   <= range_hi;
            rh_s2_r   <= rh_s1_r;
            rtog_s1_r <= rx_tog_r;
            rtog_s2_r <= rtog_s1_r;
            rtog_s3_r <= rtog_s2_r;
            ack_s1_r  <= tx_ack_r;
            ack_s2_r  <= ack_s1_r;
            wake_s1_r <= wake_r;
            wake_s2_r <= wake_s1_r;
            wp_prot_r <= ~wp_s2_r; // RQ13 RQ14
        end
    end

    assign cs_rise = cs_s2_r && !cs_s3_r;
    assign rx_evt  = rtog_s2_r ^ rtog_s3_r;

    // Received bytes wait here until the buffer has room; a stalled drain
    // lets a later byte replace this one, as the link itself cannot pause.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pend_r      <= 1'b0;
            pend_data_r <= '0;
        end else if (rx_evt) begin
            pend_r      <= 1'b1;
            pend_data_r <= rx_hold_r;
        end else if (buf_in_ready) begin
            pend_r      <= 1'b0;
        end
    end

    sfct_buf #(
        .W     (BYTE_W),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (pend_r),
        .in_ready  (buf_in_ready),
        .in_data   (pend_data_r),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    assign tx_ready = (tx_req_r == ack_s2_r);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_req_r  <= 1'b0;
            tx_hold_r <= TX_IDLE_BYTE;
        end else if (tx_valid && tx_ready) begin
            tx_req_r  <= ~tx_req_r;
            tx_hold_r <= tx_data;
        end
    end

    // Counts are trimmed by the chip select synchroniser delay.
    function automatic logic [CNT_W-1:0] load_cycles(input sfct_op_t op, input logic hi);
        logic [CNT_W-1:0] n;
        n = CNT_W'(SWRST_CYC - SYNC_CYC);
        case (op)
            SFCT_OP_XFER:       n = CNT_W'(XFR_CYC - SYNC_CYC);
            SFCT_OP_COMP:       n = CNT_W'(COMP_CYC - SYNC_CYC);
            SFCT_OP_PAGE_EP:    n = CNT_W'(P_EP_CYC - SYNC_CYC);
            SFCT_OP_DPD_ENTER:  n = CNT_W'(EDPD_CYC - SYNC_CYC);
            SFCT_OP_DPD_RESUME: n = CNT_W'(RDPD_CYC - SYNC_CYC);
            SFCT_OP_UDPD_ENTER: n = CNT_W'(EUDPD_CYC - SYNC_CYC);
            SFCT_OP_WAKE:       n = hi ? CNT_W'(XUDPD_HI_CYC - SYNC_CYC) : CNT_W'(P_XUDPD_WIDE_CYC - SYNC_CYC);
            default:            n = CNT_W'(SWRST_CYC - SYNC_CYC);
        endcase
        load_cycles = n;
    endfunction

    assign op_ok = (pwr_r == SFCT_PWR_ACTIVE) ?
                       (op_req.code != SFCT_OP_DPD_RESUME && op_req.code != SFCT_OP_WAKE &&
                        !(op_req.code == SFCT_OP_PAGE_EP && wp_prot_r)) :
                   (pwr_r == SFCT_PWR_DPD) ? (op_req.code == SFCT_OP_DPD_RESUME) : 1'b0;
    assign op_ready = (state_r == SFCT_ST_IDLE) && op_ok;
    assign op_take  = op_valid && op_ready;
    assign wake_go  = (state_r == SFCT_ST_IDLE) && (pwr_r == SFCT_PWR_UDPD) && wake_s2_r;
    assign run_done = (state_r == SFCT_ST_RUN) && (cnt_r == CNT_ONE);

    always_comb begin
        state_nxt = state_r;
        pwr_nxt   = pwr_r;
        case (state_r)
            SFCT_ST_IDLE: begin
                if (wake_go) begin
                    state_nxt = SFCT_ST_RUN; // RQ10
                end else if (op_take) begin
                    state_nxt = SFCT_ST_ARMED;
                end
            end
            SFCT_ST_ARMED: begin
                if (cs_rise) begin
                    state_nxt = SFCT_ST_RUN; // RQ17
                end
            end
            SFCT_ST_RUN: begin
                if (run_done) begin
                    state_nxt = SFCT_ST_IDLE; // RQ17
                    case (cur_op_r)
                        SFCT_OP_DPD_ENTER:  pwr_nxt = SFCT_PWR_DPD; // RQ11
                        SFCT_OP_UDPD_ENTER: pwr_nxt = SFCT_PWR_UDPD; // RQ8
                        SFCT_OP_DPD_RESUME: pwr_nxt = SFCT_PWR_ACTIVE; // RQ12
                        SFCT_OP_WAKE:       pwr_nxt = SFCT_PWR_ACTIVE; // RQ10
                        SFCT_OP_SW_RESET:   pwr_nxt = SFCT_PWR_ACTIVE;
                        default:            pwr_nxt = pwr_r;
                    endcase
                end
            end
            default: state_nxt = SFCT_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r  <= SFCT_ST_IDLE;
            pwr_r    <= SFCT_PWR_ACTIVE;
            cur_op_r <= SFCT_OP_XFER;
            cnt_r    <= CNT_ZERO;
            age_r    <= CNT_ZERO;
        end else begin
            state_r <= state_nxt;
            pwr_r   <= pwr_nxt;
            if (wake_go) begin
                cur_op_r <= SFCT_OP_WAKE;
                cnt_r    <= load_cycles(SFCT_OP_WAKE, rh_s2_r); // RQ10
            end else if (op_take) begin
                cur_op_r <= op_req.code;
            end else if (state_r == SFCT_ST_ARMED && cs_rise) begin
                cnt_r <= load_cycles(cur_op_r, rh_s2_r); // RQ6 RQ7 RQ15
            end else if (state_r == SFCT_ST_RUN) begin
                cnt_r <= cnt_r - CNT_ONE;
            end
            age_r <= (state_nxt == SFCT_ST_RUN && state_r == SFCT_ST_RUN) ? age_r + CNT_ONE : CNT_ZERO;
        end
    end

    assign status = '{busy: (state_r != SFCT_ST_IDLE), wp_prot: wp_prot_r, range_hi: rh_s2_r, pwr: pwr_r};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    AST_XFR_BOUND: assert property (state_r == SFCT_ST_RUN && cur_op_r == SFCT_OP_XFER |-> age_r < AST_XFR) // RQ6
        else $error("Transfer ran past its limit.");
    AST_COMP_BOUND: assert property (state_r == SFCT_ST_RUN && cur_op_r == SFCT_OP_COMP |-> age_r < AST_COMP) // RQ7
        else $error("Compare ran past its limit.");
    AST_UDPD_ENTRY: assert property (state_r == SFCT_ST_ARMED && cur_op_r == SFCT_OP_UDPD_ENTER && cs_rise // RQ8
        |-> ##[1:AST_EUDPD] pwr_r == SFCT_PWR_UDPD)
        else $error("Shutdown not reached in time.");
    AST_UDPD_EXIT: assert property (state_r == SFCT_ST_RUN && cur_op_r == SFCT_OP_WAKE // RQ10
        |-> age_r < (rh_s2_r ? XUDPD_HI_CYC : P_XUDPD_WIDE_CYC))
        else $error("Wake from shutdown too slow.");
    AST_DPD_ENTRY: assert property (state_r == SFCT_ST_ARMED && cur_op_r == SFCT_OP_DPD_ENTER && cs_rise // RQ11
        |-> ##[1:AST_EDPD] pwr_r == SFCT_PWR_DPD)
        else $error("Power-down not entered in time.");
    AST_DPD_RESUME: assert property (state_r == SFCT_ST_ARMED && cur_op_r == SFCT_OP_DPD_RESUME && cs_rise // RQ12
        |-> ##[1:AST_RDPD] pwr_r == SFCT_PWR_ACTIVE && !status.busy)
        else $error("Resume from power-down too slow.");
    AST_WP_ON: assert property ($fell(wp_n) |-> ##[1:AST_WP] wp_prot_r) // RQ13
        else $error("Protection not enforced in time.");
    AST_WP_OFF: assert property ($rose(wp_n) |-> ##[1:AST_WP] !wp_prot_r) // RQ14
        else $error("Protection not lifted in time.");
    AST_EP_BOUND: assert property (state_r == SFCT_ST_RUN && cur_op_r == SFCT_OP_PAGE_EP // RQ15
        |-> age_r < (rh_s2_r ? P_EP_MAX_HI_CYC : P_EP_MAX_WIDE_CYC))
        else $error("Erase and program ran past its limit.");
    AST_BUSY_END: assert property ($fell(status.busy) |-> $past(state_r) == SFCT_ST_RUN && $past(cnt_r) == CNT_ONE) // RQ17
        else $error("Ready shown before the operation ended.");
    AST_RX_BYTE: assert property (@(posedge sck) disable iff (lrst) // RQ4
        rbit_r == BIT_LAST |=> rx_hold_r == $past(rx_next))
        else $error("Received byte not captured on its last rising edge.");
endmodule

// ---- tb/sfct_host.sv ----
/*
 * Host-side model of the serial link: drives chip select, link clock and
 * serial input, and samples serial output on falling edges.
 * Assumes the bench pulses go; the link clock idles low outside frames.
 */
module sfct_host (
    input  wire logic        go,
    input  wire logic        pulse_only,
    input  wire logic [7:0]  low_ns,
    input  wire logic [15:0] mosi,
    input  wire logic        so,
    output logic             sck,
    output logic             cs_n,
    output logic             si,
    output logic [7:0]       miso,
    output logic             done
);
    timeunit 1ns;
    timeprecision 1ps;
    int i;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
        miso = 8'h00;
        done = 1'b0;
    end
    always @(posedge go) begin
        #7;
        cs_n = 1'b0;
        if (pulse_only) begin
            #(low_ns);
        end else begin
            si = mosi[15];
            #24;
            for (i = 0; i < 16; i++) begin
                sck = 1'b1;
                #2;
                if (i < 15) si = mosi[14-i];
                #21;
                if (i >= 8) miso[15-i] = so;
                #1;
                sck = 1'b0;
                #24;
            end
        end
        cs_n = 1'b1;
        // A released line shows the inverse so a stale value never passes.
        si = ~si;
        done = 1'b1;
        #30;
        done = 1'b0;
    end
endmodule

// ---- tb/serial_flash_full_cycle_timing_test.sv ----
/*
 * Self-checking bench for the full-cycle link and operation timers.
 * Assumes the host model stands on the link; long counts are shortened.
 */
module serial_flash_full_cycle_timing_test
    import sfct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EP = 200;
    localparam int XW = 100;
    logic         clock, rst, so, so_oe, wp_n, range_hi, op_valid, op_ready;
    logic         rx_valid, rx_ready, tx_valid, tx_ready, sck, cs_n, si, go, pulse_only, done;
    logic [7:0]   rx_data, tx_data, miso, low_ns;
    logic [15:0]  mosi;
    sfct_op_req_t op_req;
    sfct_status_t status;
    int           error_cnt, cmp_count;
    sfct_core #(.P_EP_CYC(EP), .P_XUDPD_WIDE_CYC(XW)) sfct_core_inst (.clock(clock), .rst(rst), .sck(sck),
        .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .range_hi(range_hi), .op_valid(op_valid),
        .op_req(op_req), .op_ready(op_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .status(status));
    sfct_host sfct_host_inst (.go(go), .pulse_only(pulse_only), .low_ns(low_ns), .mosi(mosi), .so(so), .sck(sck),
        .cs_n(cs_n), .si(si), .miso(miso), .done(done));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic give_verdict();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic frame(input logic p);
        int k;
        @(posedge clock);
        go <= 1'b1;
        pulse_only <= p;
        @(posedge clock);
        go <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 2000) begin
            #1;
            k++;
        end
        if (k >= 2000) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic meas(input int n, input sfct_pwr_t p, input int k0);
        int k;
        k = k0;
        repeat (k0) @(posedge clock);
        #1;
        while (status.busy === 1'b1 && k < n + 20) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk_rng(k, n - 2, n + 3);
        chk8(8'(status.pwr), 8'(p));
        if (k >= n + 20) give_verdict();
    endtask
    task automatic run_op(input sfct_op_t c, input int n, input sfct_pwr_t p);
        @(posedge clock);
        op_req <= '{code: c};
        op_valid <= 1'b1;
        @(posedge clock);
        op_valid <= 1'b0;
        #1;
        chk8(8'(status.busy), 8'h01);
        frame(1'b1);
        meas(n, p, 0);
    endtask
    task automatic refuse(input sfct_op_t c);
        @(posedge clock);
        op_req <= '{code: c};
        @(posedge clock);
        #1;
        chk8(8'(op_ready), 8'h00);
    endtask
    task automatic link(input logic [15:0] m, input logic [7:0] t);
        int k;
        @(posedge clock);
        tx_valid <= 1'b1;
        tx_data <= t;
        mosi <= m;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (tx_ready !== 1'b1 && k < 20);
        if (tx_ready !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
        tx_valid <= 1'b0;
        frame(1'b0);
        chk8(miso, t);
        // Both entries fill while the drain side stalls.
        repeat (12) @(posedge clock);
        #1;
        chk8(8'(rx_valid), 8'h01);
        chk8(rx_data, m[15:8]);
        for (k = 0; k < 2; k++) begin
            @(posedge clock);
            rx_ready <= 1'b1;
            @(posedge clock);
            rx_ready <= 1'b0;
            #1;
            if (k == 0) chk8(rx_data, m[7:0]);
        end
        chk8(8'(rx_valid), 8'h00);
    endtask
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        range_hi = 1'b0;
        op_valid = 1'b0;
        op_req = '{code: SFCT_OP_XFER};
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        go = 1'b0;
        pulse_only = 1'b0;
        mosi = 16'h0000;
        // Command frames stay low past two core clocks so the synchronised
        // chip select sees them; only wake pulses are shorter.
        low_ns = 8'h78;
        error_cnt = 0;
        cmp_count = 0;
        void'($urandom(36889));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        link(16'hA501, 8'h80);
        repeat (4) link(16'($urandom), 8'($urandom));
        @(posedge clock);
        wp_n <= 1'b0;
        repeat (20) @(posedge clock);
        #1;
        chk8(8'(status.wp_prot), 8'h01);
        refuse(SFCT_OP_PAGE_EP);
        @(posedge clock);
        wp_n <= 1'b1;
        repeat (20) @(posedge clock);
        #1;
        chk8(8'(status.wp_prot), 8'h00);
        run_op(SFCT_OP_XFER, XFR_CYC, SFCT_PWR_ACTIVE);
        run_op(SFCT_OP_COMP, COMP_CYC, SFCT_PWR_ACTIVE);
        run_op(SFCT_OP_PAGE_EP, EP, SFCT_PWR_ACTIVE);
        run_op(SFCT_OP_DPD_ENTER, EDPD_CYC, SFCT_PWR_DPD);
        refuse(SFCT_OP_XFER);
        run_op(SFCT_OP_DPD_RESUME, RDPD_CYC, SFCT_PWR_ACTIVE);
        run_op(SFCT_OP_SW_RESET, SWRST_CYC, SFCT_PWR_ACTIVE);
        run_op(SFCT_OP_UDPD_ENTER, EUDPD_CYC, SFCT_PWR_UDPD);
        refuse(SFCT_OP_DPD_RESUME);
        low_ns = 8'h1E;
        frame(1'b1);
        meas(XW, SFCT_PWR_ACTIVE, 5);
        low_ns = 8'h78;
        @(posedge clock);
        range_hi <= 1'b1;
        run_op(SFCT_OP_UDPD_ENTER, EUDPD_CYC, SFCT_PWR_UDPD);
        low_ns = 8'h1E;
        frame(1'b1);
        meas(XUDPD_HI_CYC, SFCT_PWR_ACTIVE, 5);
        link(16'($urandom), 8'($urandom));
        give_verdict();
    end
endmodule
